// ==== hw/sci_pkg.sv ====
package sci_pkg;
   // register map and field positions
   localparam logic [7:0] fmt_ctrl_addr = 8'h0e;
   localparam logic [7:0] data_port_addr = 8'h11;
   localparam logic [7:0] data_reset = 8'h00;
   localparam int rx8_pos = 7;
   localparam int tx8_pos = 6;
   localparam int len9_pos = 4;
   localparam int wake_pos = 3;
   localparam int clock_idle_level_pos = 2;
   localparam int clock_phase_sel_pos = 1;
   localparam int last_bit_clock_en_pos = 0;
   // control register bits that are stored (bit 5 reads zero)
   localparam logic [7:0] fmt_wr_mask = 8'h5f;
   localparam logic [7:0] fmt_reset = 8'h00;
   // bit timing
   localparam logic [3:0] ticks_per_bit = 4'hf;
   localparam logic [3:0] half_bit = 4'h7;
   localparam logic [3:0] bits_8 = 4'h8;
   localparam logic [3:0] bits_9 = 4'h9;
   localparam logic [3:0] pre_8 = 4'ha;
   localparam logic [3:0] pre_9 = 4'hb;
   localparam logic [3:0] wake_run_8 = 4'hb;
   localparam logic [3:0] wake_run_9 = 4'hc;
   typedef enum logic [2:0] {
      tx_off, tx_idle, tx_pre, tx_brk, tx_start, tx_data, tx_stop
   } tx_state_e;
endpackage : sci_pkg

// ==== hw/sync_if.sv ====
// two-flop synchronised rx pin level and sample-tick rising-edge pulse handed to the main block
interface sync_if;
   logic rx_pin;
   logic tick;
   modport src (output rx_pin, output tick);
   modport dst (input rx_pin, input tick);
endinterface : sync_if

// ==== hw/pin_sync.sv ====
// brings rx pin and sample tick into clk_i domain
module pin_sync (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic serial_rx_pin_i,
   input wire logic sample_tick_i,
   sync_if.src out
);
   logic [1:0] rx_ff;
   logic [1:0] tk_ff;
   logic tk_d;
   // two flops per pin, edge found after the second
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rx_ff <= 2'h3;
         tk_ff <= 2'h0;
         tk_d <= 1'b0;
      end
      else
      begin
         rx_ff <= {rx_ff[0], serial_rx_pin_i};
         tk_ff <= {tk_ff[0], sample_tick_i};
         tk_d <= tk_ff[1];
      end
   end
   assign out.rx_pin = rx_ff[1];
   assign out.tick = tk_ff[1] & ~tk_d; // rising edge of the 16x clock
endmodule : pin_sync

// ==== hw/rx_core.sv ====
// receive shift path, holding register and wake-up
module rx_core
   import sci_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   sync_if.dst pins,
   input wire logic len9_i,
   input wire logic wake_i,
   input wire logic rx_en_i,
   input wire logic sleep_set_i,
   input wire logic full_clr_i,
   output logic sleep_o,
   output logic full_o,
   output logic [7:0] hold_o,
   output logic ninth_o
);
   logic busy;
   logic [3:0] tcnt;
   logic [3:0] bcnt;
   logic [8:0] sh;
   logic [3:0] ones;
   logic [3:0] nbits;
   logic lastbit;
   logic done;
   assign nbits = len9_i ? bits_9 : bits_8;
   assign lastbit = len9_i ? sh[8] : sh[7];
   assign done = busy && pins.tick && tcnt == half_bit && bcnt == nbits + 4'h1;
   // frame sampler, mid-bit, lsb first
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         busy <= 1'b0;
         tcnt <= 4'h0;
         bcnt <= 4'h0;
         sh <= 9'h000;
      end
      else if (!busy)
      begin
         bcnt <= 4'h0; // timer free-runs while idle so idle ones get counted
         if (rx_en_i && pins.tick && !pins.rx_pin)
         begin
            busy <= 1'b1;
            tcnt <= 4'h0;
         end
         else if (pins.tick)
            tcnt <= tcnt + 4'h1;
      end
      else if (pins.tick)
      begin
         tcnt <= tcnt + 4'h1;
         if (tcnt == half_bit)
         begin
            bcnt <= bcnt + 4'h1;
            if (bcnt == 4'h0 && pins.rx_pin)
               busy <= 1'b0; // false start
            else if (bcnt != 4'h0 && bcnt <= nbits)
               sh <= len9_i ? {pins.rx_pin, sh[8:1]}
                            : {1'b0, pins.rx_pin, sh[7:1]};
            if (done)
               busy <= 1'b0;
         end
      end
   end
   // holding register, ninth bit and full flag
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         hold_o <= data_reset;
         ninth_o <= 1'b0;
         full_o <= 1'b0;
      end
      else if (done && !sleep_o && !full_o)
      begin
         hold_o <= sh[7:0];
         ninth_o <= sh[8];
         full_o <= 1'b1;
      end
      else if (done && sleep_o && wake_i && lastbit)
      begin
         hold_o <= sh[7:0]; // address char wakes and lands
         ninth_o <= sh[8];
         full_o <= 1'b1;
      end
      else if (full_clr_i)
         full_o <= 1'b0;
   end
   // sleep bit, idle-run or address-mark wake
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         sleep_o <= 1'b0;
         ones <= 4'h0;
      end
      else
      begin
         if (pins.tick && tcnt == half_bit)
            ones <= !pins.rx_pin ? 4'h0 : (ones == 4'hf ? ones : ones + 4'h1);
         if (sleep_o && !wake_i
             && ones >= (len9_i ? wake_run_9 : wake_run_8))
            sleep_o <= 1'b0;
         else if (sleep_o && wake_i && done && lastbit)
            sleep_o <= 1'b0;
         else if (sleep_set_i)
            sleep_o <= 1'b1;
      end
   end
endmodule : rx_core

// ==== hw/serial_tx_sync_clock_format.sv ====
module serial_tx_sync_clock_format
   import sci_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic sample_tick_i,
   input wire logic tx_enable_i,
   input wire logic rx_enable_i,
   input wire logic send_break_i,
   input wire logic receiver_sleep_set_i,
   input wire logic status_read_i,
   output logic receiver_sleep_o,
   output logic tx_empty_flag_o,
   output logic tx_complete_o,
   output logic rx_full_flag_o,
   input wire logic serial_rx_pin_i,
   output logic tx_data_o,
   output logic tx_data_oe_o,
   output logic sync_clk_o,
   output logic sync_clk_oe_o
);
   import sci_pkg::*;

   sync_if pins ();
   logic [7:0] fmt;
   logic [7:0] tx_holding_reg;
   logic [7:0] rx_holding_reg;
   logic rx_ninth_bit;
   logic rx_full_flag;
   logic tx_empty_flag;
   logic tx_armed;
   logic rx_armed;
   logic te_q;
   logic pre_req;
   tx_state_e state;
   tx_state_e next_state;
   logic [3:0] tcnt;
   logic [3:0] bcnt;
   logic [8:0] shreg;
   logic bit_end;
   logic load;
   logic [3:0] nbits;
   logic clk_win;
   logic next_sclk;
   logic len9;

   // decode helper for the two mapped addresses
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction : hit

   pin_sync u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .serial_rx_pin_i(serial_rx_pin_i),
      .sample_tick_i(sample_tick_i),
      .out(pins)
   );

   rx_core u_rx (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .pins(pins),
      .len9_i(len9),
      .wake_i(fmt[wake_pos]),
      .rx_en_i(rx_enable_i),
      .sleep_set_i(receiver_sleep_set_i),
      .full_clr_i(rx_armed && rd_i && hit(addr_i, data_port_addr)),
      .sleep_o(receiver_sleep_o),
      .full_o(rx_full_flag),
      .hold_o(rx_holding_reg),
      .ninth_o(rx_ninth_bit)
   );

   assign len9 = fmt[len9_pos]; // shared length select
   assign nbits = len9 ? bits_9 : bits_8;

   // format control: every bit except 7 and 5, wake select included, writable any time
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         fmt <= fmt_reset;
      else if (wr_i && hit(addr_i, fmt_ctrl_addr))
         fmt <= wdata_i & fmt_wr_mask;
   end

   // read mux: data port returns the receive holding register
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         rdata_o <= data_reset;
      else if (rd_i && hit(addr_i, data_port_addr))
         rdata_o <= rx_holding_reg;
      else if (rd_i && hit(addr_i, fmt_ctrl_addr))
         rdata_o <= {rx_ninth_bit, fmt[6:0]};
      else if (rd_i)
         rdata_o <= 8'h00;
   end

   // transmit holding register is write-only
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         tx_holding_reg <= data_reset;
      else if (wr_i && hit(addr_i, data_port_addr))
         tx_holding_reg <= wdata_i;
   end

   // status-read arming for the two-step flag clears
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         tx_armed <= 1'b0;
         rx_armed <= 1'b0;
      end
      else
      begin
         if (status_read_i)
         begin
            tx_armed <= tx_empty_flag;
            rx_armed <= rx_full_flag;
         end
         else if (wr_i && hit(addr_i, data_port_addr))
            tx_armed <= 1'b0;
         else if (rd_i && hit(addr_i, data_port_addr))
            rx_armed <= 1'b0;
      end
   end

   // empty flag: load sets, armed write clears; set wins
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         tx_empty_flag <= 1'b1;
      else if (load)
         tx_empty_flag <= 1'b1;
      else if (tx_armed && wr_i && hit(addr_i, data_port_addr))
         tx_empty_flag <= 1'b0;
   end

   // bit timer on sample ticks: sixteen per bit
   assign bit_end = pins.tick && tcnt == ticks_per_bit;
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         tcnt <= 4'h0;
      else if (state == tx_off)
         tcnt <= 4'h0;
      else if (pins.tick)
         tcnt <= tcnt + 4'h1;
   end

   // enable edge requests a preamble, also on re-enable mid-byte
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         te_q <= 1'b0;
         pre_req <= 1'b0;
      end
      else
      begin
         te_q <= tx_enable_i;
         if (tx_enable_i && !te_q)
            pre_req <= 1'b1;
         else if (state == tx_pre)
            pre_req <= 1'b0;
      end
   end

   // at a bit boundary a waiting byte moves to the shifter
   assign load = bit_end && tx_enable_i && !pre_req && !send_break_i
                 && !tx_empty_flag
                 && (state == tx_idle || state == tx_stop
                     || (state == tx_pre && bcnt == nbits + 4'h1));

   // transmit sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         tx_off:
            if (tx_enable_i)
               next_state = tx_pre;
         tx_idle, tx_stop:
            if (bit_end)
            begin
               if (!tx_enable_i)
                  next_state = tx_off; // byte done, then release
               else if (pre_req)
                  next_state = tx_pre;
               else if (send_break_i)
                  next_state = tx_brk;
               else if (load)
                  next_state = tx_start;
               else
                  next_state = tx_idle;
            end
         tx_pre:
            if (bit_end && bcnt == nbits + 4'h1)
               next_state = load ? tx_start : tx_idle;
         tx_brk:
            if (bit_end && bcnt == nbits + 4'h1)
               next_state = tx_stop; // one high bit after break
         tx_start:
            if (bit_end)
               next_state = tx_data;
         tx_data:
            if (bit_end && bcnt == nbits - 4'h1)
               next_state = tx_stop;
         default:
            next_state = tx_off;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         state <= tx_off;
      else
         state <= next_state;
   end

   // bit counter per state
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         bcnt <= 4'h0;
      else if (next_state != state)
         bcnt <= 4'h0;
      else if (bit_end)
         bcnt <= bcnt + 4'h1;
   end

   // shifter loads byte plus ninth bit, shifts lsb first
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         shreg <= 9'h1ff;
      else if (load)
         shreg <= {fmt[tx8_pos], tx_holding_reg};
      else if (state == tx_data && bit_end)
         shreg <= {1'b1, shreg[8:1]};
   end

   // data pin level per state, registered
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         tx_data_o <= 1'b1;
      else
         case (next_state)
            tx_start, tx_brk: tx_data_o <= 1'b0;
            tx_data: tx_data_o <= shreg[0];
            default: tx_data_o <= 1'b1;
         endcase
   end

   // clock only within data bits; last bit gated unless format bit 0 is set
   assign clk_win = state == tx_data
                    && (fmt[last_bit_clock_en_pos] || bcnt != nbits - 4'h1);
   always_comb
   begin
      next_sclk = fmt[clock_idle_level_pos]; // steady idle level
      if (clk_win)
      begin
         if (fmt[clock_phase_sel_pos])
            next_sclk = (tcnt <= half_bit) ^ fmt[clock_idle_level_pos];
         else
            next_sclk = (tcnt > half_bit) ^ fmt[clock_idle_level_pos];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         sync_clk_o <= 1'b0;
      else
         sync_clk_o <= next_sclk;
   end

   // pins float while disabled and idle
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         tx_data_oe_o <= 1'b0;
         sync_clk_oe_o <= 1'b0;
      end
      else
      begin
         tx_data_oe_o <= next_state != tx_off;
         sync_clk_oe_o <= next_state != tx_off;
      end
   end

   assign tx_empty_flag_o = tx_empty_flag;
   assign rx_full_flag_o = rx_full_flag;
   assign tx_complete_o = state == tx_idle || state == tx_off;
endmodule : serial_tx_sync_clock_format

// ==== dv/serial_tx_sync_clock_format_properties.sv ====
module tx_fmt_checker
   import sci_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic sample_tick_i,
   input wire logic tx_enable_i,
   input wire logic status_read_i,
   input wire logic tx_empty_flag_o,
   input wire logic tx_complete_o,
   input wire logic rx_full_flag_o,
   input wire logic tx_data_o,
   input wire logic tx_data_oe_o,
   input wire logic sync_clk_o,
   input wire logic sync_clk_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [7:0] fmt;
   logic [8:0] tk;
   logic [7:0] sc;
   logic tick_q;
   logic oe_q;
   logic pre;
   int pre_t;
   // preamble length in sample ticks
   assign pre_t = fmt[len9_pos] ? 176 : 160;
   // shadow of the stored format bits
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         fmt <= fmt_reset;
      else if (wr_i && addr_i == fmt_ctrl_addr)
         fmt <= wdata_i & fmt_wr_mask;
   end
   // edge memories for tick and data enable
   always_ff @(posedge clk_i)
   begin
      tick_q <= sample_tick_i;
      oe_q <= tx_data_oe_o;
   end
   // window from enable to the first low bit
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i || !tx_data_oe_o)
         pre <= 1'b0;
      else if (!oe_q)
         pre <= 1'b1;
      else if (!tx_data_o || tx_complete_o)
         pre <= 1'b0; // preamble ended by a start bit or by going idle
   end
   // tick rises counted inside that window
   always_ff @(posedge clk_i)
   begin
      if (!pre)
         tk <= '0;
      else if (sample_tick_i && !tick_q)
         tk <= tk + 9'd1;
   end
   // cycles into the start bit after the preamble
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         sc <= '0;
      else if (pre && !tx_data_o)
         sc <= 8'd1;
      else if (sc != 8'd0 && sc < 8'd150)
         sc <= sc + 8'd1;
      else
         sc <= '0;
   end
   property p_reset_state;
      $rose(nrst_i) |-> tx_empty_flag_o && !rx_full_flag_o
         && !tx_data_oe_o && !sync_clk_oe_o;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs wrong after reset");
   property p_release_off;
      $fell(tx_data_oe_o) |-> !tx_enable_i && !sync_clk_oe_o;
   endproperty
   a_release_off: assert property (p_release_off)
      else $error("pins released while enabled");
   property p_preamble_len;
      pre && $fell(tx_data_o) |-> tk >= pre_t - 15 && tk <= pre_t + 1;
   endproperty
   a_preamble_len: assert property (p_preamble_len)
      else $error("preamble length wrong");
   property p_preamble_quiet;
      pre && $past(pre) |-> $stable(sync_clk_o);
   endproperty
   a_preamble_quiet: assert property (p_preamble_quiet)
      else $error("clock moved in preamble");
   property p_start_quiet;
      sc != 8'd0 |-> $stable(sync_clk_o);
   endproperty
   a_start_quiet: assert property (p_start_quiet)
      else $error("clock moved in start bit");
   property p_idle_level;
      tx_complete_o && sync_clk_oe_o && $past(sync_clk_oe_o)
         |-> sync_clk_o == fmt[clock_idle_level_pos];
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle clock level wrong");
   property p_fmt_read;
      rd_i && addr_i == fmt_ctrl_addr |=> rdata_o[6:0] == fmt[6:0];
   endproperty
   a_fmt_read: assert property (p_fmt_read)
      else $error("format readback wrong");
   property p_unmapped;
      rd_i && addr_i != fmt_ctrl_addr && addr_i != data_port_addr
         |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_empty_clear;
      status_read_i && tx_empty_flag_o
         ##1 wr_i && addr_i == data_port_addr && !tx_enable_i
         |=> !tx_empty_flag_o;
   endproperty
   a_empty_clear: assert property (p_empty_clear)
      else $error("empty flag not cleared");
   property p_load_driving;
      $rose(tx_empty_flag_o) |-> tx_data_oe_o;
   endproperty
   a_load_driving: assert property (p_load_driving)
      else $error("load while not driving");
endmodule : tx_fmt_checker

bind serial_tx_sync_clock_format tx_fmt_checker chk (.clk_i(clk_i),
   .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .sample_tick_i(sample_tick_i),
   .tx_enable_i(tx_enable_i), .status_read_i(status_read_i),
   .tx_empty_flag_o(tx_empty_flag_o), .tx_complete_o(tx_complete_o),
   .rx_full_flag_o(rx_full_flag_o), .tx_data_o(tx_data_o),
   .tx_data_oe_o(tx_data_oe_o), .sync_clk_o(sync_clk_o),
   .sync_clk_oe_o(sync_clk_oe_o));

// ==== dv/sync_shift_peer.sv ====
module sync_shift_peer (
   input wire logic clk_i,
   input wire logic len9_i,
   input wire logic data_i,
   input wire logic data_oe_i,
   input wire logic sclk_i,
   input wire logic sclk_oe_i,
   output logic line_o,
   output logic [8:0] word_o,
   output logic [8:0] pulses_o,
   output logic [7:0] frames_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] tog = '0;
   logic [8:0] tog0;
   logic sclk_q = 1'b0;
   // released data line is pulled up, else looped to the receiver
   assign line_o = data_oe_i ? data_i : 1'b1;
   // every driven clock change is half a pulse
   always @(posedge clk_i)
   begin
      sclk_q <= sclk_i;
      if (sclk_oe_i && sclk_i !== sclk_q)
         tog <= tog + 9'd1;
   end
   // receive one frame at mid-bit, 160 clocks a bit
   initial
   begin
      word_o = '0;
      pulses_o = '0;
      frames_o = '0;
      busy_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (data_oe_i && !data_i)
         begin
            busy_o = 1'b1;
            tog0 = tog;
            word_o = '0;
            repeat (80) @(posedge clk_i);
            for (int b = 0; b < (len9_i ? 10 : 9); b++)
            begin
               repeat (160) @(posedge clk_i);
               if (b < (len9_i ? 9 : 8))
                  word_o[b] = data_i;
            end
            pulses_o = (tog - tog0) >> 1;
            frames_o = frames_o + 8'd1;
            busy_o = 1'b0;
         end
      end
   end
endmodule : sync_shift_peer

// ==== dv/serial_tx_sync_clock_format_test.sv ====
module serial_tx_sync_clock_format_test
   import sci_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_s;
   localparam row_s rows [4] = '{'{8'h0e, 8'hff, 8'h5f},
      '{8'h0e, 8'h08, 8'h08}, '{8'h0e, 8'h00, 8'h00}, '{8'h3a, 8'hff, 8'h00}};
   localparam logic [7:0] dv [4] = '{8'h5a, 8'hc3, 8'h01, 8'h80};
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic tick = 1'b0;
   logic [7:0] addr = '0;
   logic [7:0] wdata = '0;
   logic wr = 1'b0, rd = 1'b0, tx_en = 1'b0, rx_en = 1'b0, stat = 1'b0;
   logic len9 = 1'b0;
   logic brk = 1'b0;
   logic [7:0] rdata_o, frames;
   logic rx_pin, empty, full, txd, txd_oe, sclk, sclk_oe, busy;
   logic [8:0] word, pulses;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   // system clock and free-running sample tick
   initial forever #4 clk_i = ~clk_i;
   initial forever #40 tick = ~tick;
   serial_tx_sync_clock_format dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata_o), .sample_tick_i(tick), .tx_enable_i(tx_en),
      .rx_enable_i(rx_en), .send_break_i(brk),
      .receiver_sleep_set_i(1'b0), .status_read_i(stat),
      .receiver_sleep_o(), .tx_empty_flag_o(empty), .tx_complete_o(),
      .rx_full_flag_o(full), .serial_rx_pin_i(rx_pin), .tx_data_o(txd),
      .tx_data_oe_o(txd_oe), .sync_clk_o(sclk), .sync_clk_oe_o(sclk_oe));
   sync_shift_peer peer (.clk_i(clk_i), .len9_i(len9), .data_i(txd),
      .data_oe_i(txd_oe), .sclk_i(sclk), .sclk_oe_i(sclk_oe),
      .line_o(rx_pin), .word_o(word), .pulses_o(pulses),
      .frames_o(frames), .busy_o(busy));
   // hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [8:0] seen,
      input logic [8:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask : rd_reg
   // status read pulse, then optionally a data write right after it
   task automatic status(input logic do_wr, input logic [7:0] d);
      @(negedge clk_i);
      stat = 1'b1;
      @(negedge clk_i);
      stat = 1'b0;
      addr = data_port_addr;
      wdata = d;
      wr = do_wr;
      @(negedge clk_i);
      wr = 1'b0;
   endtask : status
   task automatic hold_for(ref logic s, input logic v);
      int n = 4000;
      while (s !== v && n > 0)
      begin
         @(negedge clk_i);
         n--;
      end
      chk("wait", s, v);
   endtask : hold_for
   // main sequence
   initial
   begin
      logic [7:0] v;
      logic [7:0] f;
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      foreach (rows[i])
      begin
         wr_reg(rows[i].a, rows[i].w);
         rd_reg(rows[i].a, v);
         chk("reg row", v, rows[i].e);
      end
      $display("register rows done");
      wr_reg(fmt_ctrl_addr, 8'h5f);
      nrst_i = 1'b0;
      repeat (16) @(negedge clk_i);
      nrst_i = 1'b1;
      rd_reg(data_port_addr, v);
      chk("data port", v, data_reset);
      rd_reg(fmt_ctrl_addr, v);
      chk("format", v, fmt_reset);
      chk("tx empty", empty, 1'b1);
      chk("data oe", txd_oe, 1'b0);
      chk("clock oe", sclk_oe, 1'b0);
      $display("reset test done");
      rx_en = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         f = {1'b0, ~i[0], 1'b0, i[1], 1'b0, i[0] ^ i[1], i[1], i[0]};
         len9 = i[1];
         wr_reg(fmt_ctrl_addr, f);
         status(1'b1, dv[i]);
         tx_en = 1'b1;
         hold_for(busy, 1'b1);
         tx_en = 1'b0;
         hold_for(txd_oe, 1'b0);
         chk("frames", frames, 9'(i + 1));
         chk("word", word, {f[6] & i[1], dv[i]});
         chk("pulses", pulses, 9'(7 + i[0] + i[1]));
         chk("tx empty", empty, 1'b1);
         hold_for(full, 1'b1);
         rd_reg(fmt_ctrl_addr, v);
         if (i[1])
            chk("rx ninth", v, {f[6], f[6:0]});
         status(1'b0, 8'h00);
         rd_reg(data_port_addr, v);
         chk("rx byte", v, dv[i]);
         chk("rx full", full, 1'b0);
         $display("frame test %0d done", i);
      end
      // enabled with nothing to send: preamble, idle line, then a break
      tx_en = 1'b1;
      repeat (2400) @(negedge clk_i);
      chk("idle data", txd, 1'b1);
      chk("idle clock", sclk, 1'b0);
      brk = 1'b1;
      hold_for(busy, 1'b1);
      brk = 1'b0;
      hold_for(busy, 1'b0);
      chk("break word", word, 9'h000);
      chk("break pulses", pulses, 9'h000);
      tx_en = 1'b0;
      hold_for(txd_oe, 1'b0);
      $display("idle and break test done");
      wrap_up();
   end
endmodule : serial_tx_sync_clock_format_test
